/* File: watchdog_params.svh */
// Register offsets, field positions, reset values and key for the watchdog
`ifndef WATCHDOG_PARAMS_SVH
`define WATCHDOG_PARAMS_SVH
`define WD_ADDR_W 12
`define WD_OFF_RELOAD 12'h000
`define WD_OFF_VALUE 12'h004
`define WD_OFF_CONTROL 12'h008
`define WD_OFF_CLEAR 12'h00c
`define WD_OFF_RAW 12'h010
`define WD_OFF_MASKED 12'h014
`define WD_OFF_GUARD 12'hc00
`define WD_BIT_IRQ_EN 0
`define WD_BIT_RST_EN 1
`define WD_RELOAD_RESET 32'hffffffff
`define WD_UNLOCK_KEY 32'h1acce551
`define WD_GUARD_LOCKED 32'h00000001
`define WD_GUARD_UNLOCKED 32'h00000000
`endif

/* File: watchdog_pkg.sv */
// Types shared by the watchdog design
package watchdog_pkg;
  typedef logic [31:0] word_type;
  typedef logic [11:0] addr_type;
endpackage : watchdog_pkg

/* File: watchdog_counter.sv */
// Down counter with load and zero detection for the watchdog
module watchdog_counter #(
  parameter int WIDTH = 32
) (
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic load,
  input wire logic [WIDTH-1:0] load_value,
  input wire logic run,
  output logic [WIDTH-1:0] count,
  output logic at_zero
);
  initial
  begin
    if (WIDTH < 2 || WIDTH > 32)
    begin
      $error("watchdog_counter: WIDTH out of range");
    end
  end

  // Load wins over decrement, so a reload never loses a cycle to the count
  always_ff @(posedge ref_clk)
  begin
    if (!rst_n)
    begin
      count <= '1;
    end
    else if (load)
    begin
      count <= load_value;
    end
    else if (run && count != '0)
    begin
      count <= count - WIDTH'(1);
    end
  end

  assign at_zero = (count == '0);
endmodule : watchdog_counter

/* File: watchdog_timer_two_stage.sv */
// Two-stage watchdog: time-out interrupt, then system reset request
//
// The address-and-strobe port and the register addresses are this design's own decisions.
`include "watchdog_params.svh"

module watchdog_timer_two_stage #(
  parameter int WIDTH = 32
) (
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire watchdog_pkg::addr_type reg_addr,
  input wire watchdog_pkg::word_type reg_wdata,
  input wire logic reg_write,
  input wire logic reg_read,
  output watchdog_pkg::word_type reg_rdata,
  output logic nmi_request,
  output logic reset_request
);
  import watchdog_pkg::*;

  // Field positions and offsets must leave the decode unambiguous
  initial
  begin
    if (WIDTH != 32)
    begin
      $error("watchdog_timer_two_stage: only a 32-bit counter is served");
    end
    if (`WD_BIT_IRQ_EN == `WD_BIT_RST_EN)
    begin
      $error("watchdog_timer_two_stage: control fields overlap");
    end
    if (`WD_BIT_IRQ_EN > 31 || `WD_BIT_RST_EN > 31)
    begin
      $error("watchdog_timer_two_stage: control field outside the word");
    end
    if (`WD_GUARD_LOCKED == `WD_GUARD_UNLOCKED)
    begin
      $error("watchdog_timer_two_stage: guard readback cannot show the lock state");
    end
    if (`WD_OFF_GUARD == `WD_OFF_RELOAD || `WD_OFF_GUARD == `WD_OFF_CLEAR)
    begin
      $error("watchdog_timer_two_stage: guard offset collides with a locked register");
    end
  end

  // --------------------------------------------------------------------
  // Register state
  // --------------------------------------------------------------------
  word_type interval_reload_reg;
  logic timeout_irq_enable;
  logic reset_output_enable;
  logic access_locked;
  logic timeout_flag;
  logic zero_seen;
  logic counter_load;
  word_type counter_load_value;
  word_type count;
  logic at_zero;

  function automatic logic hit(input addr_type a, input addr_type off);
    hit = (a == off);
  endfunction : hit

  // Control readback follows the field positions, not a fixed layout
  function automatic word_type control_word(input logic irq_en, input logic rst_en);
    control_word = 32'h00000000;
    control_word[`WD_BIT_IRQ_EN] = irq_en;
    control_word[`WD_BIT_RST_EN] = rst_en;
  endfunction : control_word

  function automatic word_type flag_word(input logic flag);
    flag_word = {31'h0, flag};
  endfunction : flag_word

  // --------------------------------------------------------------------
  // Write decode
  // --------------------------------------------------------------------
  logic wr_reload;
  logic wr_control;
  logic wr_clear;
  logic wr_guard;
  logic enable_rise;
  logic any_load;

  // The guard register is always writable, otherwise a lock could never be lifted
  always_comb
  begin
    wr_reload = 1'b0;
    wr_control = 1'b0;
    wr_clear = 1'b0;
    wr_guard = 1'b0;
    if (!reg_write)
    begin
      wr_guard = 1'b0;
    end
    else if (hit(reg_addr, `WD_OFF_GUARD))
    begin
      wr_guard = 1'b1;
    end
    else if (access_locked)
    begin
      // Locked: every other register ignores the write
      wr_reload = 1'b0;
    end
    else if (hit(reg_addr, `WD_OFF_RELOAD))
    begin
      wr_reload = 1'b1;
    end
    else if (hit(reg_addr, `WD_OFF_CONTROL))
    begin
      // Control ignores writes once the interrupt enable is set
      wr_control = !timeout_irq_enable;
    end
    else if (hit(reg_addr, `WD_OFF_CLEAR))
    begin
      wr_clear = 1'b1;
    end
  end

  assign enable_rise = wr_control && reg_wdata[`WD_BIT_IRQ_EN];
  // A write that loads the counter itself hides a zero seen in the same cycle
  assign any_load = wr_reload || wr_clear || enable_rise;

  // --------------------------------------------------------------------
  // Register writes
  // --------------------------------------------------------------------
  always_ff @(posedge ref_clk)
  begin
    if (!rst_n)
    begin
      interval_reload_reg <= `WD_RELOAD_RESET;
    end
    else if (wr_reload)
    begin
      interval_reload_reg <= reg_wdata;
    end
  end

  always_ff @(posedge ref_clk)
  begin
    if (!rst_n)
    begin
      timeout_irq_enable <= 1'b0;
      reset_output_enable <= 1'b0;
    end
    else if (wr_control)
    begin
      // Only reset brings the enable back low, so the write can only set it
      timeout_irq_enable <= reg_wdata[`WD_BIT_IRQ_EN];
      reset_output_enable <= reg_wdata[`WD_BIT_RST_EN];
    end
  end

  always_ff @(posedge ref_clk)
  begin
    if (!rst_n)
    begin
      access_locked <= 1'b0;
    end
    else if (wr_guard)
    begin
      access_locked <= (reg_wdata != `WD_UNLOCK_KEY);
    end
  end

  // --------------------------------------------------------------------
  // Counter control
  // --------------------------------------------------------------------
  // Zero is seen once per pass; the reload in the same cycle starts the next pass
  logic timeout_event;
  // Masked by the write decode, not by counter_load, so counter_load never feeds back into itself
  assign timeout_event = timeout_irq_enable && at_zero && !any_load;

  always_comb
  begin
    counter_load = 1'b0;
    counter_load_value = interval_reload_reg;
    if (wr_reload)
    begin
      counter_load = 1'b1;
      counter_load_value = reg_wdata;
    end
    else if (wr_clear || enable_rise)
    begin
      counter_load = 1'b1;
    end
    else if (timeout_event)
    begin
      counter_load = 1'b1;
    end
  end

  watchdog_counter #(
    .WIDTH(WIDTH)
  ) counter (
    .ref_clk(ref_clk),
    .rst_n(rst_n),
    .load(counter_load),
    .load_value(counter_load_value),
    .run(timeout_irq_enable),
    .count(count),
    .at_zero(at_zero)
  );

  // --------------------------------------------------------------------
  // Time-out flag and reset request
  // --------------------------------------------------------------------
  // Zero written, enabled or not: the counter loads zero, so flag now
  logic zero_write;
  assign zero_write = wr_reload && reg_wdata == '0;

  always_ff @(posedge ref_clk)
  begin
    if (!rst_n)
    begin
      timeout_flag <= 1'b0;
    end
    else if (timeout_event || zero_write)
    begin
      // Set wins over a clear in the same cycle; a reload write never clears
      timeout_flag <= 1'b1;
    end
    else if (wr_clear)
    begin
      timeout_flag <= 1'b0;
    end
  end

  always_ff @(posedge ref_clk)
  begin
    if (!rst_n)
    begin
      zero_seen <= 1'b0;
    end
    else
    begin
      zero_seen <= timeout_event && timeout_flag && reset_output_enable;
    end
  end

  always_ff @(posedge ref_clk)
  begin
    if (!rst_n)
    begin
      reset_request <= 1'b0;
    end
    else if (zero_seen)
    begin
      reset_request <= 1'b1;
    end
  end

  always_ff @(posedge ref_clk)
  begin
    if (!rst_n)
    begin
      nmi_request <= 1'b0;
    end
    else
    begin
      // Non-maskable: follows the flag whenever the watchdog is enabled
      nmi_request <= timeout_flag && timeout_irq_enable;
    end
  end

  // --------------------------------------------------------------------
  // Read port
  // --------------------------------------------------------------------
  word_type next_rdata;

  // Reads have no side effects, so the decode is purely combinational
  always_comb
  begin
    next_rdata = 32'h00000000;
    if (!reg_read)
    begin
      next_rdata = 32'h00000000;
    end
    else if (hit(reg_addr, `WD_OFF_RELOAD))
    begin
      next_rdata = interval_reload_reg;
    end
    else if (hit(reg_addr, `WD_OFF_VALUE))
    begin
      next_rdata = count;
    end
    else if (hit(reg_addr, `WD_OFF_CONTROL))
    begin
      next_rdata = control_word(timeout_irq_enable, reset_output_enable);
    end
    else if (hit(reg_addr, `WD_OFF_RAW))
    begin
      next_rdata = flag_word(timeout_flag);
    end
    else if (hit(reg_addr, `WD_OFF_MASKED))
    begin
      next_rdata = flag_word(timeout_flag && timeout_irq_enable);
    end
    else if (hit(reg_addr, `WD_OFF_GUARD))
    begin
      next_rdata = access_locked ? `WD_GUARD_LOCKED : `WD_GUARD_UNLOCKED;
    end
    else
    begin
      // Unmapped offsets and the write-only clear register read zero
      next_rdata = 32'h00000000;
    end
  end

  // Read data stand for one cycle only and are zero otherwise
  always_ff @(posedge ref_clk)
  begin
    if (!rst_n)
    begin
      reg_rdata <= 32'h00000000;
    end
    else
    begin
      reg_rdata <= next_rdata;
    end
  end
endmodule : watchdog_timer_two_stage

/* File: watchdog_system_model.sv */
// Interrupt input and system reset logic facing the watchdog
module watchdog_system_model (
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic nmi_request,
  input wire logic reset_request,
  output logic [7:0] nmi_taken,
  output logic sys_reset
);
  timeunit 1ns;
  timeprecision 1ps;
  logic nmi_last;
  // No mask stage: every rising request is taken
  always_ff @(posedge ref_clk)
  begin
    nmi_last <= nmi_request;
    if (!rst_n)
      nmi_taken <= 8'h00;
    else if (nmi_request && !nmi_last)
      nmi_taken <= nmi_taken + 8'h01;
  end
  // Held until the bench pulses the block reset
  always_ff @(posedge ref_clk)
  begin
    if (!rst_n)
      sys_reset <= 1'b0;
    else if (reset_request)
      sys_reset <= 1'b1;
  end
endmodule : watchdog_system_model

/* File: watchdog_timer_two_stage_checker.sv */
// Port assertions for the two-stage watchdog
`include "watchdog_params.svh"
module watchdog_checker
  import watchdog_pkg::*;
#(
  parameter int WIDTH = 32
) (
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire watchdog_pkg::addr_type reg_addr,
  input wire watchdog_pkg::word_type reg_wdata,
  input wire logic reg_write,
  input wire logic reg_read,
  input wire watchdog_pkg::word_type reg_rdata,
  input wire logic nmi_request,
  input wire logic reset_request
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!rst_n);
  wire logic wr_guard = reg_write && reg_addr == `WD_OFF_GUARD;
  wire logic rd_guard = reg_read && reg_addr == `WD_OFF_GUARD;
  wire logic wr_ctl = reg_write && reg_addr == `WD_OFF_CONTROL;
  wire logic wr_clear = reg_write && reg_addr == `WD_OFF_CLEAR;
  wire logic rd_raw = reg_read && reg_addr == `WD_OFF_RAW;
  AST_KEY_OPENS: assert property (wr_guard && reg_wdata == `WD_UNLOCK_KEY ##2 rd_guard
    |=> reg_rdata == `WD_GUARD_UNLOCKED) else $error("guard key did not unlock");
  AST_ANY_LOCKS: assert property (wr_guard && reg_wdata != `WD_UNLOCK_KEY ##2 rd_guard
    |=> reg_rdata == `WD_GUARD_LOCKED) else $error("guard write did not lock");
  AST_ZERO_RAISES: assert property (reg_write && reg_addr == `WD_OFF_RELOAD
    && reg_wdata == 32'h0 ##1 !wr_clear ##1 rd_raw |=> reg_rdata[0])
    else $error("zero interval no flag");
  AST_CLEAR_DROPS: assert property (wr_clear ##2 rd_raw |=> !reg_rdata[0])
    else $error("clear left flag set");
  AST_CTL_LOCKED: assert property (wr_ctl && reg_wdata[0] ##2 wr_ctl ##2 reg_read
    && reg_addr == `WD_OFF_CONTROL |=> reg_rdata[0]) else $error("control not locked");
  AST_RST_NEEDS_NMI: assert property ($rose(reset_request) |-> nmi_request)
    else $error("reset without pending interrupt");
  AST_RST_STICKY: assert property (reset_request |=> reset_request)
    else $error("reset request dropped");
  AST_NMI_ONLY_CLEAR: assert property ($fell(nmi_request) |-> $past(wr_clear, 2))
    else $error("interrupt fell without clear");
endmodule : watchdog_checker
bind watchdog_timer_two_stage watchdog_checker #(.WIDTH(WIDTH)) i_watchdog_checker (
  .ref_clk(ref_clk), .rst_n(rst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
  .reg_write(reg_write), .reg_read(reg_read), .reg_rdata(reg_rdata),
  .nmi_request(nmi_request), .reset_request(reset_request));

/* File: watchdog_timer_two_stage_tb.sv */
// Self-checking bench for the two-stage watchdog
`include "watchdog_params.svh"
module watchdog_timer_two_stage_tb;
  timeunit 1ns;
  timeprecision 1ps;
  import watchdog_pkg::*;
  typedef struct {addr_type a; word_type d;} row_type;
  logic ref_clk = 1'b0;
  logic rst_n = 1'b0;
  addr_type reg_addr = 12'h000;
  word_type reg_wdata = 32'h0;
  logic reg_write = 1'b0;
  logic reg_read = 1'b0;
  word_type reg_rdata;
  logic nmi_request;
  logic reset_request;
  logic [7:0] nmi_taken;
  logic sys_reset;
  int n_errors = 0;
  int check_count = 0;
  int k;
  row_type rows[8] = '{'{`WD_OFF_RELOAD, `WD_RELOAD_RESET}, '{`WD_OFF_VALUE, 32'hffffffff},
    '{`WD_OFF_CONTROL, 32'h0}, '{`WD_OFF_CLEAR, 32'h0}, '{`WD_OFF_RAW, 32'h0},
    '{`WD_OFF_MASKED, 32'h0}, '{`WD_OFF_GUARD, `WD_GUARD_UNLOCKED}, '{12'h020, 32'h0}};
  // Clock gate assumed open: the bench clock runs from time zero
  initial forever #2.5 ref_clk = ~ref_clk;
  watchdog_timer_two_stage i_watchdog_timer_two_stage (.ref_clk(ref_clk), .rst_n(rst_n),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_write(reg_write), .reg_read(reg_read),
    .reg_rdata(reg_rdata), .nmi_request(nmi_request), .reset_request(reset_request));
  watchdog_system_model i_watchdog_system_model (.ref_clk(ref_clk), .rst_n(rst_n),
    .nmi_request(nmi_request), .reset_request(reset_request), .nmi_taken(nmi_taken),
    .sys_reset(sys_reset));
  // ----------------------------------------------------------------
  // Bus tasks: one idle cycle follows every strobe
  // ----------------------------------------------------------------
  task automatic stop_test();
    $display("errors %0d checks %0d", n_errors, check_count);
    if (n_errors == 0 && check_count > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask : stop_test
  task automatic chk(input word_type got, input word_type exp);
    check_count++;
    if (got !== exp)
    begin
      $display("[FAIL] %0t got %h exp %h", $time, got, exp);
      n_errors++;
    end
  endtask : chk
  task automatic wr(input addr_type a, input word_type d);
    @(posedge ref_clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_write <= 1'b1;
    @(posedge ref_clk);
    reg_write <= 1'b0;
  endtask : wr
  task automatic rd(input addr_type a, input word_type exp);
    @(posedge ref_clk);
    reg_addr <= a;
    reg_read <= 1'b1;
    @(posedge ref_clk);
    reg_read <= 1'b0;
    #1 chk(reg_rdata, exp);
  endtask : rd
  // Counts settled edges until the chosen output reaches lvl
  task automatic wait_for(input bit rst_sel, input logic lvl, output int n);
    n = 0;
    while ((rst_sel ? reset_request : nmi_request) !== lvl)
    begin
      if (n == 80)
      begin
        n_errors++;
        stop_test();
      end
      @(posedge ref_clk);
      #1 n++;
    end
  endtask : wait_for
  task automatic do_reset();
    @(posedge ref_clk);
    rst_n <= 1'b0;
    repeat (8) @(posedge ref_clk);
    rst_n <= 1'b1;
  endtask : do_reset
  initial
  begin
    do_reset();
    foreach (rows[i])
      rd(rows[i].a, rows[i].d);
    wr(`WD_OFF_RELOAD, 32'h0000000a);
    wr(`WD_OFF_CONTROL, 32'h00000002);
    wr(`WD_OFF_CONTROL, 32'h00000003);
    wr(`WD_OFF_CONTROL, 32'h00000000);
    rd(`WD_OFF_CONTROL, 32'h00000003);
    // Interval 10: zero 10 edges after enable, flag 1 and nmi 2 more, 4 spent on bus
    wait_for(1'b0, 1'b1, k);
    chk(k, 32'd8);
    wait_for(1'b1, 1'b1, k);
    chk(k, 32'd11);
    repeat (3) @(posedge ref_clk);
    #1 chk(reset_request, 1'b1);
    chk({sys_reset, nmi_taken}, 9'h101);
    do_reset();
    chk(reset_request, 1'b0);
    wr(`WD_OFF_RELOAD, 32'h00000014);
    wr(`WD_OFF_CONTROL, 32'h00000003);
    wr(`WD_OFF_RELOAD, 32'h00000032);
    rd(`WD_OFF_VALUE, 32'h00000031);
    wait_for(1'b0, 1'b1, k);
    wr(`WD_OFF_RELOAD, 32'h00000028);
    rd(`WD_OFF_MASKED, 32'h00000001);
    wr(`WD_OFF_CLEAR, 32'h00000000);
    rd(`WD_OFF_RAW, 32'h00000000);
    wait_for(1'b0, 1'b1, k);
    chk(k, 32'd40);
    chk(reset_request, 1'b0);
    wr(`WD_OFF_GUARD, 32'h00000005);
    rd(`WD_OFF_GUARD, `WD_GUARD_LOCKED);
    wr(`WD_OFF_RELOAD, 32'h00000007);
    rd(`WD_OFF_RELOAD, 32'h00000028);
    wr(`WD_OFF_GUARD, `WD_UNLOCK_KEY);
    rd(`WD_OFF_GUARD, `WD_GUARD_UNLOCKED);
    do_reset();
    wr(`WD_OFF_RELOAD, 32'h00000000);
    rd(`WD_OFF_RAW, 32'h00000001);
    // Read data stand one cycle only, then fall back to zero
    @(posedge ref_clk);
    #1 chk(reg_rdata, 32'h00000000);
    stop_test();
  end
endmodule : watchdog_timer_two_stage_tb
